// file: rpm_pkg.sv
// Purpose: shared constants and carrier types for reset and power mode control
// Assumes: mclk is the oscillator clock, 200 MHz; one machine cycle is 12 clocks
// Notes: register offsets are byte addresses on the plain register port
package rpm_pkg;

  // machine cycle and reset pin timing, in oscillator periods
  localparam int OSC_PER_MC = 12;
  localparam int RST_HOLD_OSC = 24;
  localparam int RST_HOLD_MC = RST_HOLD_OSC / OSC_PER_MC;
  localparam logic [3:0] MC_LAST = 4'(OSC_PER_MC - 1);
  localparam logic [1:0] RST_SAMPLES = 2'(RST_HOLD_MC);

  // register map
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PORT_LATCH0 = 8'h01;
  localparam logic [7:0] OFS_PORT_LATCH1 = 8'h02;
  localparam logic [7:0] OFS_PORT_LATCH2 = 8'h03;
  localparam logic [7:0] OFS_PORT_LATCH3 = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h05;

  // power_control field positions
  localparam int BIT_IDLE = 0;
  localparam int BIT_PDOWN = 1;
  localparam int BIT_GF_LOW = 2;
  localparam int BIT_GF_HIGH = 3;
  localparam int BIT_BAUD_DBL = 7;
  localparam logic [7:0] POWER_CONTROL_WRITE_MASK = 8'h8f; // bits 6..4 reserved, read zero

  // reset values
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SFR_ZERO_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_PDOWN = 2'b10
  } rpm_mode_t;

  // an 8-bit port: value driven and per-bit output enable
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } rpm_port_t;

  // a one-bit strobe pin
  typedef struct packed {
    logic dout;
    logic oe;
  } rpm_strobe_t;

endpackage

// file: rpm_ctrl.sv
// Purpose: reset recognition, idle and power-down control, pin states in low power
// Assumes: the cpu core applies the reset values from rpm_pkg while cpu_reset is high
// Notes: mclk stands for the oscillator; osc_run low marks it stopped in power-down
//
// Behaviour
// - reset needs the pin high for two machine cycles, 24 oscillator periods
// - internal reset starts in second high machine cycle, repeats until pin low
// - during reset the two strobe pins become quasi-bidirectional inputs
// - reset loads pc, pointers, stack 07h, ports 0ffh, other registers zero
// - reset leaves the on-chip data ram unchanged
// - writing the idle bit makes that write the last instruction before idle
// - idle stops the cpu clock; interrupt, timer, serial logic keep clocking
// - idle keeps cpu registers and port states; strobes stay high
// - an enabled interrupt clears the idle bit and ends idle
// - a reset also ends idle; two machine cycles suffice
// - bit 7 doubles serial baud rate in modes 1 to 3; bits 6..4 reserved
// - bits 3 and 2 are general flags with no hardware effect
// - writing power-down and idle together enters power-down, idle ignored
// - power control resets to 0xxx0000
// - writing the power-down bit stops the oscillator after that write
// - power-down keeps state; ports drive latches; strobes driven low
// - only a reset leaves power-down; it restarts the oscillator
// - external program: port 0 floats; port 2 address in idle, latch in power-down
// - after return from interrupt one instruction runs; equal priority blocks
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module rpm_ctrl
  import rpm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic rst_pin,
  input wire logic ext_prog_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic irq_wake,
  input wire logic irq_taken,
  input wire logic irq_taken_high,
  input wire logic return_from_interrupt_done,
  input wire logic instr_done,
  input wire logic ale_core,
  input wire logic prog_store_strobe_core,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] addr_hi,
  output logic cpu_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic baud_double,
  output logic irq_allow_low,
  output logic irq_allow_high,
  output rpm_strobe_t ale_pin,
  output rpm_strobe_t prog_store_strobe,
  output rpm_port_t port0,
  output rpm_port_t port1,
  output rpm_port_t port2,
  output rpm_port_t port3
);

  logic rst_meta;
  logic rst_sync;
  logic ext_meta;
  logic ext_sync;
  logic [3:0] mc_phase;
  logic mc_tick;
  logic [1:0] hi_count;
  logic rst_active;
  rpm_mode_t mode;
  logic [7:0] power_control;
  logic [7:0] port_latch [4];
  logic power_control_wr;
  logic inprog_low;
  logic inprog_high;
  logic return_from_interrupt_block;
  logic [7:0] next_rdata;
  rpm_port_t next_port [4];
  rpm_strobe_t next_ale;
  rpm_strobe_t next_prog_store_strobe;

  // two-flop synchronisers for the pins; only the second flop is read
  // pin synchronised
  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      rst_meta <= rst_pin;
      rst_sync <= rst_meta;
      ext_meta <= ext_prog_pin;
      ext_sync <= ext_meta;
    end
  end

  // machine cycle phase counter, free running so reset detection never stalls
  always_ff @(posedge mclk) begin
    if (reset) begin
      mc_phase <= '0;
    end else if (mc_phase == MC_LAST) begin
      mc_phase <= '0;
    end else begin
      mc_phase <= mc_phase + 4'h1;
    end
  end

  assign mc_tick = (mc_phase == MC_LAST);

  // count consecutive high samples, one sample per machine cycle; a high pulse
  // of 12 periods or less covers at most one sample and never reaches the threshold
  // two cycle hold
  always_ff @(posedge mclk) begin
    if (reset) begin
      hi_count <= '0;
    end else if (mc_tick) begin
      if (!rst_sync) begin
        hi_count <= '0;
      end else if (hi_count != RST_SAMPLES) begin
        hi_count <= hi_count + 2'h1;
      end
    end
  end

  // internal reset: raised on the second high sample, held every cycle until
  // a low sample; it also serves as the exit from both low-power modes
  // reset asserted
  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_active <= 1'b0;
    end else if (mc_tick) begin
      rst_active <= rst_sync && (hi_count + 2'h1 >= RST_SAMPLES);
    end
  end

  assign power_control_wr = reg_wr && (reg_addr == OFS_POWER_CONTROL);

  // power_control register; the idle bit is cleared by hardware on wake
  // reset value
  always_ff @(posedge mclk) begin
    if (reset || rst_active) begin
      power_control <= POWER_CONTROL_RESET;
    end else if (power_control_wr) begin
      power_control <= reg_wdata & POWER_CONTROL_WRITE_MASK;
      if (reg_wdata[BIT_PDOWN]) begin
        power_control[BIT_IDLE] <= 1'b0;
      end
    end else if (mode == MODE_IDLE && irq_wake) begin
      power_control[BIT_IDLE] <= 1'b0;
    end
  end

  // mode sequencer: the power_control write is the last instruction before the mode
  // idle entry
  always_ff @(posedge mclk) begin
    if (reset || rst_active) begin
      mode <= MODE_RUN;
    end else begin
      case (mode)
        MODE_RUN: begin
          if (power_control_wr && reg_wdata[BIT_PDOWN]) begin
            mode <= MODE_PDOWN;
          end else if (power_control_wr && reg_wdata[BIT_IDLE]) begin
            mode <= MODE_IDLE;
          end
        end
        MODE_IDLE: begin
          if (irq_wake) begin
            mode <= MODE_RUN;
          end
        end
        MODE_PDOWN: begin
          mode <= MODE_PDOWN;
        end
        default: begin
          mode <= MODE_RUN;
        end
      endcase
    end
  end

  // port latches; reset only touches registers, there is no ram clear path
  // ports to 0ffh
  generate
    for (genvar p = 0; p < 4; p++) begin : g_latch
      always_ff @(posedge mclk) begin
        if (reset || rst_active) begin
          port_latch[p] <= PORT_RESET;
        end else if (reg_wr && reg_addr == OFS_PORT_LATCH0 + 8'(p)) begin
          port_latch[p] <= reg_wdata;
        end
      end
    end
  endgenerate

  // interrupt acceptance: track levels in progress and the one-instruction
  // gap after a return, so a level-held request cannot re-enter at once
  // acceptance gate
  always_ff @(posedge mclk) begin
    if (reset || rst_active) begin
      inprog_low <= 1'b0;
      inprog_high <= 1'b0;
      return_from_interrupt_block <= 1'b0;
    end else begin
      if (irq_taken && irq_taken_high) begin
        inprog_high <= 1'b1;
      end else if (irq_taken) begin
        inprog_low <= 1'b1;
      end else if (return_from_interrupt_done && inprog_high) begin
        inprog_high <= 1'b0;
      end else if (return_from_interrupt_done) begin
        inprog_low <= 1'b0;
      end
      if (return_from_interrupt_done) begin
        return_from_interrupt_block <= 1'b1;
      end else if (instr_done) begin
        return_from_interrupt_block <= 1'b0;
      end
    end
  end

  // registered acceptance outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_allow_low <= 1'b0;
      irq_allow_high <= 1'b0;
    end else begin
      irq_allow_low <= !inprog_low && !inprog_high && !return_from_interrupt_block && !return_from_interrupt_done;
      irq_allow_high <= !inprog_high && !return_from_interrupt_block && !return_from_interrupt_done;
    end
  end

  // clock gating and control outputs, all from flops
  // cpu clock gated
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_reset <= 1'b0;
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_run <= 1'b1;
      baud_double <= 1'b0;
    end else begin
      cpu_reset <= rst_active;
      cpu_clk_en <= (mode == MODE_RUN);
      periph_clk_en <= (mode != MODE_PDOWN);
      osc_run <= (mode != MODE_PDOWN);
      baud_double <= power_control[BIT_BAUD_DBL];
    end
  end

  // pin state per mode; idle drives both strobes high and keeps the ports on their latches; with
  // external program port 0 floats and port 2 holds the high address byte frozen by the gated cpu clock
  // idle pins
  always_comb begin
    next_ale = '{dout: ale_core, oe: 1'b1};
    next_prog_store_strobe = '{dout: prog_store_strobe_core, oe: 1'b1};
    for (int p = 0; p < 4; p++) begin
      next_port[p] = '{dout: port_latch[p], oe: 8'hff};
    end
    if (ext_sync && mode == MODE_RUN) begin
      next_port[0] = '{dout: addr_lo, oe: 8'hff};
      next_port[2] = '{dout: addr_hi, oe: 8'hff};
    end
    if (mode == MODE_IDLE) begin
      next_ale = '{dout: 1'b1, oe: 1'b1};
      next_prog_store_strobe = '{dout: 1'b1, oe: 1'b1};
      if (ext_sync) begin
        next_port[0] = '{dout: 8'h00, oe: 8'h00};
        next_port[2] = '{dout: addr_hi, oe: 8'hff};
      end
    end else if (mode == MODE_PDOWN) begin
      next_ale = '{dout: 1'b0, oe: 1'b1};
      next_prog_store_strobe = '{dout: 1'b0, oe: 1'b1};
      if (ext_sync) begin
        next_port[0] = '{dout: 8'h00, oe: 8'h00};
      end
    end
    if (rst_active) begin
      next_ale = '{dout: 1'b1, oe: 1'b0};
      next_prog_store_strobe = '{dout: 1'b1, oe: 1'b0};
    end
  end

  // pin registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      ale_pin <= '{dout: 1'b1, oe: 1'b0};
      prog_store_strobe <= '{dout: 1'b1, oe: 1'b0};
      port0 <= '{dout: PORT_RESET, oe: 8'hff};
      port1 <= '{dout: PORT_RESET, oe: 8'hff};
      port2 <= '{dout: PORT_RESET, oe: 8'hff};
      port3 <= '{dout: PORT_RESET, oe: 8'hff};
    end else begin
      ale_pin <= next_ale;
      prog_store_strobe <= next_prog_store_strobe;
      port0 <= next_port[0];
      port1 <= next_port[1];
      port2 <= next_port[2];
      port3 <= next_port[3];
    end
  end

  // read decode; unmapped addresses and idle bus cycles read zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (!reg_rd) begin
      next_rdata = READ_ZERO;
    end else if (reg_addr == OFS_POWER_CONTROL) begin
      next_rdata = power_control;
    end else if (reg_addr == OFS_PORT_LATCH0) begin
      next_rdata = port_latch[0];
    end else if (reg_addr == OFS_PORT_LATCH1) begin
      next_rdata = port_latch[1];
    end else if (reg_addr == OFS_PORT_LATCH2) begin
      next_rdata = port_latch[2];
    end else if (reg_addr == OFS_PORT_LATCH3) begin
      next_rdata = port_latch[3];
    end else if (reg_addr == OFS_STATUS) begin
      next_rdata = {4'h0, ext_sync, rst_active, mode};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= READ_ZERO;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  rst_assert_a: assert property (
    mc_tick && rst_sync && hi_count == 2'h1 |=> rst_active ##1 cpu_reset)
    else $error("reset not raised on second high sample");
  rst_release_a: assert property (
    mc_tick && !rst_sync |=> !rst_active)
    else $error("reset held after a low sample");
  // with the step above this keeps reset low for the whole machine cycle
  rst_steady_a: assert property (
    !mc_tick |=> $stable(rst_active))
    else $error("internal reset changed between samples");
  strobe_input_a: assert property (
    rst_active |=> !ale_pin.oe && !prog_store_strobe.oe)
    else $error("strobes driven during reset");
  idle_entry_a: assert property (
    power_control_wr && reg_wdata[BIT_IDLE] && !reg_wdata[BIT_PDOWN] && mode == MODE_RUN
      && !rst_active |=> mode == MODE_IDLE ##1 !cpu_clk_en && periph_clk_en)
    else $error("idle not entered after write");
  idle_strobe_a: assert property (
    mode == MODE_IDLE && !rst_active |=> ale_pin.dout && ale_pin.oe && prog_store_strobe.dout)
    else $error("strobes not high in idle");
  idle_wake_a: assert property (
    mode == MODE_IDLE && irq_wake && !rst_active && !power_control_wr
      |=> mode == MODE_RUN && !power_control[BIT_IDLE])
    else $error("interrupt did not end idle");
  pd_priority_a: assert property (
    power_control_wr && reg_wdata[BIT_PDOWN] && reg_wdata[BIT_IDLE] && mode == MODE_RUN
      && !rst_active |=> mode == MODE_PDOWN && !power_control[BIT_IDLE])
    else $error("power-down did not take precedence");
  pd_hold_a: assert property (
    mode == MODE_PDOWN && !rst_active |=> mode == MODE_PDOWN)
    else $error("power-down left without reset");
  pd_pins_a: assert property (
    mode == MODE_PDOWN && !rst_active |=> !osc_run && !ale_pin.dout && ale_pin.oe
      && !prog_store_strobe.dout)
    else $error("power-down pin state wrong");
  return_from_interrupt_gap_a: assert property (
    return_from_interrupt_done |=> !irq_allow_low && !irq_allow_high)
    else $error("interrupt allowed right after return");
  power_control_reset_a: assert property (
    rst_active |=> power_control == POWER_CONTROL_RESET && port_latch[1] == PORT_RESET)
    else $error("reset values not loaded");

endmodule // rpm_ctrl

`default_nettype wire

// file: rpm_core_model.sv
// Purpose: stand-in for the reset source and the cpu core around rpm_ctrl
// Assumes: one mclk domain; reset hold spans are counted in mclk periods
// Notes: the fetch address only advances while the cpu clock is enabled
`timescale 1ns/10ps
`default_nettype none

module rpm_core_model
  import rpm_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] hold_len,
  input wire logic cpu_clk_en,
  output logic rst_pin,
  output logic ale_core,
  output logic prog_store_strobe_core,
  output logic [7:0] addr_lo,
  output logic [7:0] addr_hi
);
  logic [7:0] hold_cnt = 8'h00;
  logic [15:0] fetch_addr = 16'h0000;

  // pin held high for the commanded span
  // oscillator restart is instant here, so any span covering two samples will do
  always_ff @(posedge mclk) begin
    if (go) begin
      hold_cnt <= hold_len;
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  assign rst_pin = (hold_cnt != 8'h00);

  // address walks both bytes so a stale copy on a port is caught
  always_ff @(posedge mclk) begin
    if (cpu_clk_en) begin
      fetch_addr <= fetch_addr + 16'h0103;
    end
  end
  assign addr_lo = fetch_addr[7:0];
  assign addr_hi = fetch_addr[15:8];
  assign ale_core = fetch_addr[0];
  assign prog_store_strobe_core = ~fetch_addr[0];
endmodule // rpm_core_model

`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for rpm_ctrl with the core model beside it
// Assumes: reads answer one cycle after the strobe; mode pins settle in two cycles
// Notes: read results go through a queue checked by a separate watcher
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import rpm_pkg::*;
  logic mclk, reset, rst_pin, ext_prog_pin, reg_wr, reg_rd, irq_wake, go, rd_seen;
  logic irq_taken, irq_taken_high, return_from_interrupt_done, instr_done, ale_core, prog_store_strobe_core;
  logic cpu_reset, cpu_clk_en, periph_clk_en, osc_run, baud_double;
  logic irq_allow_low, irq_allow_high;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, addr_lo, addr_hi, hold_len, r, a;
  rpm_strobe_t ale_pin, prog_store_strobe;
  rpm_port_t port0, port1, port2, port3;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int seed;

  rpm_ctrl rpm_ctrl_inst (.mclk(mclk), .reset(reset), .rst_pin(rst_pin),
    .ext_prog_pin(ext_prog_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_wake(irq_wake),
    .irq_taken(irq_taken), .irq_taken_high(irq_taken_high), .return_from_interrupt_done(return_from_interrupt_done),
    .instr_done(instr_done), .ale_core(ale_core), .prog_store_strobe_core(prog_store_strobe_core),
    .addr_lo(addr_lo), .addr_hi(addr_hi), .cpu_reset(cpu_reset), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_run(osc_run), .baud_double(baud_double),
    .irq_allow_low(irq_allow_low), .irq_allow_high(irq_allow_high), .ale_pin(ale_pin),
    .prog_store_strobe(prog_store_strobe), .port0(port0), .port1(port1),
    .port2(port2), .port3(port3));

  rpm_core_model rpm_core_model_inst (.mclk(mclk), .go(go), .hold_len(hold_len),
    .cpu_clk_en(cpu_clk_en), .rst_pin(rst_pin), .ale_core(ale_core),
    .prog_store_strobe_core(prog_store_strobe_core), .addr_lo(addr_lo), .addr_hi(addr_hi));

  // 200 MHz oscillator stand-in
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // the expectation is queued when the strobe is driven
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    exp_q.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  // one-cycle pulse on {taken, taken_high, return_from_interrupt, instr}, then the allow pair
  task automatic ev(input logic [3:0] v, input logic [1:0] e);
    @(posedge mclk);
    {irq_taken, irq_taken_high, return_from_interrupt_done, instr_done} <= v;
    @(posedge mclk);
    {irq_taken, irq_taken_high, return_from_interrupt_done, instr_done} <= 4'h0;
    cyc(2);
    chk(16'({irq_allow_high, irq_allow_low}), 16'(e));
  endtask

  // drive the reset pin, then wait under a bound for entry and exit
  task automatic pin_reset(input logic [7:0] len);
    int n;
    @(posedge mclk);
    hold_len <= len;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    while (cpu_reset !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    #1;
    chk(16'({ale_pin.oe, prog_store_strobe.oe}), 16'h0000);
    while (cpu_reset !== 1'b0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      complete_run();
    end
    cyc(3);
  endtask

  // read watcher: the answer stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(16'(reg_rdata), 16'(exp_q.pop_front()));
    end
    rd_seen <= reg_rd;
  end

  initial begin
    seed = 32'h45d4;
    {reset, ext_prog_pin, reg_wr, reg_rd, irq_wake, go} = 6'b100000;
    {irq_taken, irq_taken_high, return_from_interrupt_done, instr_done} = 4'h0;
    {reg_addr, reg_wdata, hold_len} = 24'h000000;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    // register reset values and an unmapped place
    rd(OFS_POWER_CONTROL, POWER_CONTROL_RESET);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_PORT_LATCH0 + 8'(i), PORT_RESET);
    end
    rd(8'h40, READ_ZERO);
    // interrupt gate: equal priority blocks, one instruction after return
    ev(4'h8, 2'b10);
    ev(4'hc, 2'b00);
    ev(4'h2, 2'b00);
    ev(4'h1, 2'b10);
    ev(4'h2, 2'b00);
    ev(4'h1, 2'b11);
    // power-down with both request bits, external program memory
    ext_prog_pin <= 1'b1;
    r = 8'($random(seed));
    wr(OFS_PORT_LATCH2, r);
    wr(OFS_PORT_LATCH1, ~r);
    wr(OFS_POWER_CONTROL, 8'hff);
    rd(OFS_POWER_CONTROL, 8'h8e);
    cyc(3);
    chk(16'({osc_run, periph_clk_en, cpu_clk_en, baud_double}), 16'h0001);
    chk(16'({ale_pin, prog_store_strobe}), 16'h0005);
    chk(16'(port0.oe), 16'h0000);
    chk(16'(port2), {r, 8'hff});
    chk(16'(port1), {~r, 8'hff});
    chk(16'(port3), 16'hffff);
    // neither an interrupt nor a one-sample pin pulse leaves power-down
    @(posedge mclk);
    irq_wake <= 1'b1;
    @(posedge mclk);
    irq_wake <= 1'b0;
    hold_len <= 8'd12;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    a = 8'h00;
    repeat (40) begin
      @(posedge mclk);
      a = a | 8'(cpu_reset);
    end
    chk(16'(a), 16'h0000);
    rd(OFS_STATUS, 8'h0a);
    pin_reset(8'd36);
    chk(16'({osc_run, periph_clk_en, cpu_clk_en}), 16'h0007);
    // run mode with external program: port 0 carries the low address byte
    a = addr_lo;
    cyc(1);
    chk(16'(port0), {a, 8'hff});
    rd(OFS_POWER_CONTROL, POWER_CONTROL_RESET);
    rd(OFS_PORT_LATCH2, PORT_RESET);
    // idle with both flags set, ended by an interrupt
    wr(OFS_POWER_CONTROL, 8'h0d);
    rd(OFS_STATUS, 8'h09);
    cyc(2);
    chk(16'({cpu_clk_en, periph_clk_en, osc_run}), 16'h0003);
    chk(16'({ale_pin, prog_store_strobe}), 16'h000f);
    chk(16'(port0.oe), 16'h0000);
    a = addr_hi;
    cyc(3);
    chk(16'(port2.dout), 16'(a));
    chk(16'(port1), 16'hffff);
    chk(16'(port3), 16'hffff);
    @(posedge mclk);
    irq_wake <= 1'b1;
    @(posedge mclk);
    irq_wake <= 1'b0;
    cyc(2);
    chk(16'(cpu_clk_en), 16'h0001);
    rd(OFS_POWER_CONTROL, 8'h0c);
    // idle ended by a two-cycle pin reset
    wr(OFS_POWER_CONTROL, 8'h01);
    pin_reset(8'd24);
    rd(OFS_POWER_CONTROL, POWER_CONTROL_RESET);
    // internal program memory: ports 0 and 2 keep their latches in idle
    ext_prog_pin <= 1'b0;
    wr(OFS_POWER_CONTROL, 8'h01);
    cyc(3);
    chk(16'(port0), 16'hffff);
    chk(16'(port2), 16'hffff);
    cyc(4);
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
